//--- dpsem_pkg.sv
// Shared constants, commands and pin bundles for the semaphore port controller
package dpsem_pkg;

  // ==========================================================================
  // Geometry of the semaphore space and the port pins
  localparam int FLAG_COUNT = 8;
  localparam int FLAG_IDX_W = 3;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 18;
  localparam int LANE_W = 2;
  localparam int SYNC_STAGES = 2;
  localparam int MAX_POLLS_DEF = 16;
  localparam logic FLAG_FREE = 1'b1;
  localparam logic FLAG_TAKEN = 1'b0;

  // ==========================================================================
  // Timing: figures in ns, counts derived from the clock period
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int RECOVER_NS = 20;

  // Least time rounded up to whole cycles, never below one
  function automatic int dpsem_cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = dpsem_cyc_min(SETUP_NS);
  localparam int STROBE_CYC = dpsem_cyc_min(STROBE_NS);
  localparam int RECOVER_CYC = dpsem_cyc_min(RECOVER_NS);
  localparam int READ_CYC = STROBE_CYC + SYNC_STAGES;

  // ==========================================================================
  // User commands and bundles
  typedef enum logic [1:0] {
    DPSEM_CMD_INIT = 2'h0,
    DPSEM_CMD_CLAIM = 2'h1,
    DPSEM_CMD_RELEASE = 2'h2,
    DPSEM_CMD_PEEK = 2'h3
  } dpsem_cmd_type;

  typedef struct packed {
    dpsem_cmd_type cmd;
    logic [FLAG_IDX_W-1:0] flag;
  } dpsem_req_type;

  typedef struct packed {
    logic owned;
    logic level;
  } dpsem_result_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic semaphore_select_n;
    logic rw_n;
    logic oe_n;
    logic [LANE_W-1:0] byte_lane_selects_n;
  } dpsem_pins_type;

  localparam dpsem_pins_type PINS_IDLE = '{addr: 18'h00000, ce_n: 1'b1, semaphore_select_n: 1'b1,
                                           rw_n: 1'b1, oe_n: 1'b1, byte_lane_selects_n: 2'h3};

endpackage

//--- dpsem_port_ctrl.sv
// Port controller that claims, polls, releases and initialises semaphore flags
`timescale 1ns/1ns
module dpsem_port_ctrl #(
  parameter int MAX_POLLS = dpsem_pkg::MAX_POLLS_DEF
) (
  input wire logic CLK, // 50 MHz clock
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic REQ_VALID, // Command offered
  input wire dpsem_pkg::dpsem_req_type REQ, // Command and flag index
  output logic REQ_READY, // Idle, command taken when valid
  output logic DONE, // One-cycle end of command
  output dpsem_pkg::dpsem_result_type RESULT, // Ownership and last level read
  output dpsem_pkg::dpsem_pins_type PINS, // Port control pins
  output logic [dpsem_pkg::DATA_W-1:0] DQ_DRIVE, // Data pins, driven value
  output logic DQ_OE_N, // Data pins enable, low while driving
  input wire logic [dpsem_pkg::DATA_W-1:0] DQ_SENSE // Data pins, sensed value
);
  import dpsem_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_RECOV = 4'b1000
  } dpsem_state_type;

  dpsem_state_type st_r, st_nxt;
  dpsem_req_type req_r, req_nxt;
  dpsem_result_type result_r, result_nxt;
  dpsem_pins_type pins_r, pins_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] polls_r, polls_nxt;
  logic write_r, write_nxt;
  logic wbit_r, wbit_nxt;
  logic withdraw_r, withdraw_nxt;
  logic wrote_r, wrote_nxt;
  logic level_r, level_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic dqoe_r, dqoe_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic dq_s1_r, dq_s2_r;
  logic launch, l_write, l_bit, finish, f_owned;
  logic [FLAG_IDX_W-1:0] l_flag;

  // ==========================================================================
  // Input synchroniser; every data bit carries the same flag, so bit 0 is enough
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_s1_r <= 1'b1;
      dq_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= DQ_SENSE[0];
      dq_s2_r <= dq_s1_r;
    end
  end

  // ==========================================================================
  // Access sequencer: setup, strobe, recovery, then choose the next access
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    result_nxt = result_r;
    pins_nxt = pins_r;
    polls_nxt = polls_r;
    write_nxt = write_r;
    wbit_nxt = wbit_r;
    withdraw_nxt = withdraw_r;
    wrote_nxt = wrote_r;
    level_nxt = level_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    dqoe_nxt = dqoe_r;
    dq_nxt = dq_r;
    launch = 1'b0;
    l_write = 1'b0;
    l_bit = FLAG_FREE;
    l_flag = req_r.flag;
    finish = 1'b0;
    f_owned = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (REQ_VALID && ready_r) begin
          req_nxt = REQ;
          polls_nxt = 8'h00;
          withdraw_nxt = 1'b0;
          wrote_nxt = 1'b0;
          launch = 1'b1;
          l_write = (REQ.cmd != DPSEM_CMD_PEEK);
          l_bit = (REQ.cmd == DPSEM_CMD_CLAIM) ? FLAG_TAKEN : FLAG_FREE;
          l_flag = (REQ.cmd == DPSEM_CMD_INIT) ? 3'h0 : REQ.flag;
          if (REQ.cmd == DPSEM_CMD_INIT) begin
            req_nxt.flag = 3'h0;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_r == 4'h0) begin
          // Strobe: write pulse or output enable, never both
          st_nxt = ST_PULSE;
          pins_nxt.rw_n = !write_r;
          pins_nxt.oe_n = write_r;
          cnt_nxt = write_r ? 4'(STROBE_CYC - 1) : 4'(READ_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_PULSE: begin
        if (cnt_r == 4'h0) begin
          if (!write_r) begin
            level_nxt = dq_s2_r;
          end
          // Drop select and enable so the device's read latch lets go between polls
          st_nxt = ST_RECOV;
          pins_nxt = PINS_IDLE;
          pins_nxt.addr = pins_r.addr; // Address held through write end
          cnt_nxt = 4'(RECOVER_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_RECOV: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          dqoe_nxt = 1'b1;
          unique case (req_r.cmd)
            DPSEM_CMD_INIT: begin
              if (req_r.flag != 3'(FLAG_COUNT - 1)) begin
                req_nxt.flag = req_r.flag + 3'h1;
                launch = 1'b1;
                l_write = 1'b1;
                l_flag = req_r.flag + 3'h1;
              end else begin
                finish = 1'b1;
              end
            end
            DPSEM_CMD_CLAIM: begin
              if (write_r && !withdraw_r) begin
                wrote_nxt = 1'b1;
                launch = 1'b1;
              end else if (!write_r && level_r == FLAG_TAKEN) begin
                finish = 1'b1;
                f_owned = 1'b1;
              end else if (!write_r && polls_r < 8'(MAX_POLLS)) begin
                polls_nxt = polls_r + 8'h01;
                launch = 1'b1;
              end else if (!write_r) begin
                withdraw_nxt = 1'b1;
                launch = 1'b1;
                l_write = 1'b1;
              end else begin
                finish = 1'b1;
              end
            end
            default: begin
              finish = 1'b1;
            end
          endcase
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        pins_nxt = PINS_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
    // Start one semaphore cycle: select low, chip enable high, lanes open
    if (launch) begin
      st_nxt = ST_SETUP;
      ready_nxt = 1'b0;
      cnt_nxt = 4'(SETUP_CYC - 1);
      write_nxt = l_write;
      wbit_nxt = l_bit;
      pins_nxt = PINS_IDLE;
      pins_nxt.addr = {{(ADDR_W - FLAG_IDX_W){1'b0}}, l_flag};
      pins_nxt.semaphore_select_n = 1'b0;
      pins_nxt.ce_n = 1'b1;
      pins_nxt.byte_lane_selects_n = 2'h0;
      dq_nxt = {DATA_W{l_bit}};
      dqoe_nxt = !l_write;
    end
    if (finish) begin
      st_nxt = ST_IDLE;
      ready_nxt = 1'b1;
      done_nxt = 1'b1;
      pins_nxt = PINS_IDLE;
      result_nxt.owned = f_owned;
      result_nxt.level = level_r;
    end
  end

  // Registers of the sequencer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      req_r <= '0;
      result_r <= '0;
      pins_r <= PINS_IDLE;
      polls_r <= 8'h00;
      write_r <= 1'b0;
      wbit_r <= 1'b1;
      withdraw_r <= 1'b0;
      wrote_r <= 1'b0;
      level_r <= 1'b1;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      dqoe_r <= 1'b1;
      dq_r <= 18'h3ffff;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      result_r <= result_nxt;
      pins_r <= pins_nxt;
      polls_r <= polls_nxt;
      write_r <= write_nxt;
      wbit_r <= wbit_nxt;
      withdraw_r <= withdraw_nxt;
      wrote_r <= wrote_nxt;
      level_r <= level_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      dqoe_r <= dqoe_nxt;
      dq_r <= dq_nxt;
    end
  end

  assign REQ_READY = ready_r;
  assign DONE = done_r;
  assign RESULT = result_r;
  assign PINS = pins_r;
  assign DQ_DRIVE = dq_r;
  assign DQ_OE_N = dqoe_r;

  // ==========================================================================
  // Checks on the pin protocol
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sem_select_ce_a:
    assert property (!PINS.semaphore_select_n |-> PINS.ce_n) else $error("Chip enable active during semaphore cycle");
  strobe_excl_a:
    assert property (!(!PINS.rw_n && !PINS.oe_n)) else $error("Write strobe and output enable overlap");
  write_drive_a:
    assert property (!PINS.rw_n |-> !DQ_OE_N && !PINS.semaphore_select_n) else $error("Write strobe without data drive");
  write_len_a:
    assert property ($fell(PINS.rw_n) |-> !PINS.rw_n [*2] ##1 PINS.rw_n) else $error("Write strobe length wrong");
  claim_order_a:
    assert property ($fell(PINS.oe_n) && req_r.cmd == DPSEM_CMD_CLAIM |-> wrote_r) else $error("Claim read before write");
  claim_owned_a:
    assert property (DONE && RESULT.owned |-> RESULT.level == FLAG_TAKEN) else $error("Owned without zero read");
  poll_bound_a:
    assert property (polls_r <= 8'(MAX_POLLS)) else $error("Poll count over limit");
  claim_withdraw_a:
    assert property (DONE && req_r.cmd == DPSEM_CMD_CLAIM && !RESULT.owned |-> withdraw_r && wbit_r)
      else $error("Failed claim ended without withdrawal");
  init_walk_a:
    assert property (DONE && req_r.cmd == DPSEM_CMD_INIT |-> req_r.flag == 3'(FLAG_COUNT - 1) && wbit_r)
      else $error("Init ended early");
  done_pulse_a:
    assert property (DONE |=> !DONE) else $error("Done longer than one cycle");
  lanes_open_a:
    assert property (!PINS.semaphore_select_n |-> PINS.byte_lane_selects_n == 2'h0)
      else $error("Byte lanes closed in semaphore cycle");
  poll_release_a:
    assert property ($rose(PINS.oe_n) |-> PINS.semaphore_select_n) else $error("Select held across end of read");

endmodule

//--- dpsem_dev_model.sv
// Behavioural semaphore device: eight flags, two request latches, left port on pins
`timescale 1ns/1ns
module dpsem_dev_model (
  input wire dpsem_pkg::dpsem_pins_type pins, // Left port control pins
  input wire logic [dpsem_pkg::DATA_W-1:0] ctrl_dq, // Data driven by controller
  input wire logic ctrl_oe_n, // Controller data enable, low drives
  output logic [dpsem_pkg::DATA_W-1:0] dq_wire // Resolved data line
);
  import dpsem_pkg::*;
  // ==========================================================================
  // Flag state; no power-up clearing, so start from junk ownership
  logic [FLAG_COUNT-1:0] req_l = 8'h00;
  logic [FLAG_COUNT-1:0] req_r = 8'h00;
  logic [FLAG_COUNT-1:0] own_l = 8'h5a;
  logic [FLAG_COUNT-1:0] own_r = 8'ha5;
  logic wr_act = 1'b0;
  logic wr_bit = 1'b1;
  logic [FLAG_IDX_W-1:0] wr_idx = 3'h0;
  logic rd_act = 1'b0;
  logic rd_val = 1'b0;

  // Owner frees on a one; a pending zero takes over at once; left wins a tie
  function automatic void settle(input int i);
    if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
    if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i]) begin
      if (!req_l[i]) own_l[i] = 1'b1;
      else if (!req_r[i]) own_r[i] = 1'b1;
    end
  endfunction

  // Far port, driven straight by the bench; a zero on an owned flag only waits
  task automatic right_write(input int i, input logic b);
    req_r[i] = b;
    settle(i);
  endtask

  // Left write lands when the strobe ends; flags steer nothing else
  always @(pins or dq_wire) begin
    if (!pins.semaphore_select_n && pins.ce_n && !pins.rw_n) begin
      wr_act = 1'b1;
      wr_idx = pins.addr[FLAG_IDX_W-1:0];
      wr_bit = dq_wire[0];
    end else if (wr_act && pins.rw_n) begin
      wr_act = 1'b0;
      req_l[wr_idx] = wr_bit;
      settle(int'(wr_idx));
    end
  end

  // Read value frozen while select and output enable stay low; needs at least one byte lane open
  always @(pins) begin
    if (!pins.semaphore_select_n && pins.ce_n && pins.rw_n && !pins.oe_n && pins.byte_lane_selects_n != 2'h3) begin
      if (!rd_act) rd_val = ~own_l[pins.addr[FLAG_IDX_W-1:0]];
      rd_act = 1'b1;
    end else begin
      rd_act = 1'b0;
    end
  end

  // Released bits show the inverse of the last value read, never a helpful level
  always_comb begin
    for (int b = 0; b < DATA_W; b++) begin
      if (!ctrl_oe_n) dq_wire[b] = ctrl_dq[b];
      else if (rd_act && !pins.byte_lane_selects_n[b / (DATA_W / LANE_W)]) dq_wire[b] = rd_val;
      else dq_wire[b] = ~rd_val;
    end
  end
endmodule

//--- dpsem_port_ctrl_tb_top.sv
// Self-checking bench for the semaphore port controller against a device model
`timescale 1ns/1ns
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s expected %0h seen %0h", what, exp, got); end end
module dpsem_port_ctrl_tb_top;
  import dpsem_pkg::*;
  // ==========================================================================
  // Bench signals; one poll keeps the failed claim short
  localparam int POLLS = 1;
  localparam int WR = SETUP_CYC + STROBE_CYC + RECOVER_CYC;
  localparam int RD = SETUP_CYC + READ_CYC + RECOVER_CYC;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic REQ_VALID = 1'b0;
  dpsem_req_type REQ = '0;
  logic REQ_READY;
  logic DONE;
  dpsem_result_type RESULT;
  dpsem_pins_type PINS;
  logic [DATA_W-1:0] DQ_DRIVE;
  logic DQ_OE_N;
  logic [DATA_W-1:0] DQ_SENSE;
  int fail_count = 0;
  int total_checks = 0;
  int cyc;
  dpsem_pins_type pins_c1;
  logic ready_c1;
  logic [DATA_W-1:0] dq_c1;
  logic oe_c1;

  always #10 CLK = ~CLK;

  dpsem_port_ctrl #(.MAX_POLLS(POLLS)) dpsem_port_ctrl_inst (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE), .RESULT(RESULT), .PINS(PINS), .DQ_DRIVE(DQ_DRIVE),
    .DQ_OE_N(DQ_OE_N), .DQ_SENSE(DQ_SENSE));
  dpsem_dev_model dpsem_dev_model_inst (.pins(PINS), .ctrl_dq(DQ_DRIVE), .ctrl_oe_n(DQ_OE_N), .dq_wire(DQ_SENSE));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One command from a falling edge; returns at the falling edge showing done, so calls chain back to back
  task automatic run(input dpsem_cmd_type c, input logic [2:0] f, input int exp_cyc);
    REQ = '{cmd: c, flag: f};
    REQ_VALID = 1'b1;
    while (REQ_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    @(negedge CLK);
    REQ_VALID = 1'b0;
    pins_c1 = PINS;
    ready_c1 = REQ_READY;
    dq_c1 = DQ_DRIVE;
    oe_c1 = DQ_OE_N;
    cyc = 1;
    while (DONE !== 1'b1 && cyc < 200) begin
      @(negedge CLK);
      cyc++;
    end
    `CHK("ready low", 1'b0, ready_c1)
    `CHK("done cycle", exp_cyc, cyc)
    `CHK("ready at done", 1'b1, REQ_READY)
    `CHK("lanes open", 2'h0, pins_c1.byte_lane_selects_n)
    `CHK("data enable", c == DPSEM_CMD_PEEK, oe_c1)
    if (c != DPSEM_CMD_PEEK) `CHK("write data", {DATA_W{c != DPSEM_CMD_CLAIM}}, dq_c1)
    `CHK("select low", 1'b0, pins_c1.semaphore_select_n)
    `CHK("enable high", 1'b1, pins_c1.ce_n)
    if (c != DPSEM_CMD_INIT) `CHK("flag addr", f, pins_c1.addr[2:0])
  endtask

  task automatic t_reset();
    `CHK("idle pins", PINS_IDLE, PINS)
    `CHK("data released", 1'b1, DQ_OE_N)
    `CHK("reset done", 1'b0, DONE)
  endtask

  // Junk ownership: left init hands its flags to the pending right side, right init frees all
  task automatic t_init();
    run(DPSEM_CMD_INIT, 3'h0, 1 + 8 * WR);
    `CHK("left init passes", 8'hff, dpsem_dev_model_inst.own_r)
    for (int i = 0; i < FLAG_COUNT; i++) dpsem_dev_model_inst.right_write(i, 1'b1);
    `CHK("all free", 8'h00, dpsem_dev_model_inst.own_l | dpsem_dev_model_inst.own_r)
  endtask

  // Claim, far-side request waits, release passes it, peek sees the other owner
  task automatic t_claim_pass();
    run(DPSEM_CMD_CLAIM, 3'h3, 1 + WR + RD);
    `CHK("claim owned", 2'h2, RESULT)
    dpsem_dev_model_inst.right_write(3, 1'b0);
    `CHK("left keeps", 8'h08, dpsem_dev_model_inst.own_l)
    run(DPSEM_CMD_RELEASE, 3'h3, 1 + WR);
    `CHK("right takes", 8'h08, dpsem_dev_model_inst.own_r)
    `CHK("release result", 1'b0, RESULT.owned)
    run(DPSEM_CMD_PEEK, 3'h3, 1 + RD);
    `CHK("peek taken", 2'h1, RESULT)
    dpsem_dev_model_inst.right_write(3, 1'b1);
  endtask

  // Failed claim polls then withdraws, so a later far-side release frees the flag
  task automatic t_busy();
    dpsem_dev_model_inst.right_write(5, 1'b0);
    run(DPSEM_CMD_CLAIM, 3'h5, 1 + 2 * WR + (POLLS + 1) * RD);
    `CHK("claim refused", 2'h1, RESULT)
    `CHK("withdrawn", 1'b1, dpsem_dev_model_inst.req_l[5])
    dpsem_dev_model_inst.right_write(5, 1'b1);
    `CHK("freed", 8'h00, dpsem_dev_model_inst.own_l | dpsem_dev_model_inst.own_r)
    run(DPSEM_CMD_PEEK, 3'h5, 1 + RD);
    `CHK("peek free", 2'h1, RESULT)
  endtask

  // Reset cut into a claim's write strobe: pins idle at once, then release and peek run clean
  task automatic t_abort();
    REQ = '{cmd: DPSEM_CMD_CLAIM, flag: 3'h6};
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    @(negedge CLK);
    RSTN = 1'b0;
    @(negedge CLK);
    `CHK("cut pins", PINS_IDLE, PINS)
    `CHK("cut data", 1'b1, DQ_OE_N)
    `CHK("cut state", 4'h8, {REQ_READY, DONE, RESULT})
    RSTN = 1'b1;
    @(negedge CLK);
    run(DPSEM_CMD_RELEASE, 3'h6, 1 + WR);
    `CHK("cut release", 2'h1, RESULT)
    run(DPSEM_CMD_PEEK, 3'h6, 1 + RD);
    `CHK("cut peek", 2'h1, RESULT)
    `CHK("cut free", 8'h00, dpsem_dev_model_inst.own_l | dpsem_dev_model_inst.own_r)
  endtask

  // Watchdog well past the hundred or so cycles the scenarios need
  initial begin
    #(CLK_PERIOD_NS * 3000);
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    t_reset();
    RSTN = 1'b1;
    @(negedge CLK);
    t_init();
    t_claim_pass();
    t_busy();
    t_abort();
    wrap_up();
  end
endmodule
